// ==== core/gpa_pkg.sv ====
// Notes on behaviour
// - eight pins, each usable as input or output
// - direction bit 1 turns driver off; 0 drives latch value onto pin
// - data read returns pin levels; data write updates only the latch
// - oscillator mode strap decides whether bits 6 and 7 are port pins
// - top pins not used as port: data, direction and latch bits read zero
// - analog config bits switch bits 0-3 and 5 between digital and analog
// - comparator control bits give bits 0-5 comparator inputs or outputs
// - after reset bits 0-3 and 5 are analog reading zero; bit 4 digital
// - bit 4 has open-drain output and feeds timer clock input
// - direction bits still steer drivers in analog mode; software keeps them set
// - enabled sharing peripheral owns its pin instead of general I/O
// - in RC mode bit 6 outputs clock at a quarter of the oscillator
// - bit 5 can serve as serial port slave-select input
package gpa_pkg;
	localparam int PORT_WIDTH = 8;
	localparam int ADDR_WIDTH = 12;
	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_PIN_DATA = 10'h005;
	localparam logic [9:0] IDX_DIRECTION = 10'h085;
	localparam logic [9:0] IDX_CMP_CTRL = 10'h09c;
	localparam logic [9:0] IDX_CMP_REF = 10'h09d;
	localparam logic [9:0] IDX_ANALOG_CFG = 10'h09f;
	localparam logic [11:0] ADDR_PIN_DATA = {IDX_PIN_DATA, 2'b00};
	localparam logic [11:0] ADDR_DIRECTION = {IDX_DIRECTION, 2'b00};
	localparam logic [11:0] ADDR_CMP_CTRL = {IDX_CMP_CTRL, 2'b00};
	localparam logic [11:0] ADDR_CMP_REF = {IDX_CMP_REF, 2'b00};
	localparam logic [11:0] ADDR_ANALOG_CFG = {IDX_ANALOG_CFG, 2'b00};
	// reset values
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_DIRECTION = 8'hff;
	localparam logic [7:0] RST_CMP_CTRL = 8'h07;
	localparam logic [7:0] RST_CMP_REF = 8'h00;
	localparam logic [7:0] RST_ANALOG_CFG = 8'h00;
	// field layout
	localparam int CMP_OUT_TWO_BIT = 7;
	localparam int CMP_OUT_ONE_BIT = 6;
	localparam int CMP_MODE_LSB = 0;
	localparam int CMP_RW_MSB = 5;
	localparam logic [2:0] CMP_MODE_OFF = 3'h7;
	localparam logic [2:0] CMP_MODE_OUT = 3'h6;
	localparam int CVR_EN_BIT = 7;
	localparam int CVR_OE_BIT = 6;
	localparam logic [7:0] CVR_RW_MASK = 8'hef;
	localparam int CFG_LSB = 0;
	localparam logic [3:0] CFG_ALL_DIGITAL = 4'hf;
	localparam logic [3:0] CFG_REF_LIMIT = 4'hc;
	localparam int CFG_SS_BIT = 2;
	// pin positions
	localparam int PIN_REF_OUT = 2;
	localparam int PIN_OPEN_DRAIN = 4;
	localparam int PIN_SLAVE_SEL = 5;
	localparam int PIN_OSC_OUT = 6;
	localparam int PIN_OSC_IN = 7;
	// instruction clock divider: counter wraps here, output flips twice per wrap
	localparam logic [1:0] CLK_DIV_MAX = 2'h3;

	typedef enum logic [1:0] {
		OSC_CRYSTAL = 2'b00,
		OSC_EXT_CLOCK = 2'b01,
		OSC_RC_CLKOUT = 2'b10,
		OSC_INTERNAL = 2'b11
	} gpa_osc_type;
endpackage

// ==== core/gpa_pad_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface gpa_pad_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] drive_val;
	logic [WIDTH-1:0] drive_en;
	logic [WIDTH-1:0] level;
	modport core (output drive_val, output drive_en, input level);
	modport pad (input drive_val, input drive_en, output level);
endinterface
`default_nettype wire

// ==== core/gpa_pad_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpa_pad_stage #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe,
	gpa_pad_if.pad padi
);
	logic [WIDTH-1:0] sync1_reg;
	logic [WIDTH-1:0] sync2_reg;

	// two-stage synchroniser for the pin levels
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
		end
	end

	assign padi.level = sync2_reg;

	// output drivers held in flops, released at reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_out <= '0;
			pin_oe <= '0;
		end
		else
		begin
			pin_out <= padi.drive_val;
			pin_oe <= padi.drive_en;
		end
	end
endmodule // gpa_pad_stage
`default_nettype wire

// ==== core/gpa_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpa_port #(
	parameter int WIDTH = gpa_pkg::PORT_WIDTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gpa_pkg::ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe,
	input wire logic [1:0] osc_mode_strap,
	input wire logic timer_clock_enable,
	input wire logic slave_select_enable,
	input wire logic comparator_one_output,
	input wire logic comparator_two_output,
	output logic timer_clock_input,
	output logic slave_select_n,
	output logic [WIDTH-1:0] analog_select,
	output logic [7:0] comparator_control,
	output logic [7:0] comparator_reference_control,
	output logic [7:0] analog_pin_config
);
	gpa_pad_if #(.WIDTH(WIDTH)) padi ();

	logic [WIDTH-1:0] output_latch_bits_reg;
	logic [WIDTH-1:0] port_direction_reg;
	logic [7:0] cmp_reg;
	logic [7:0] cvr_reg;
	logic [7:0] acfg_reg;
	gpa_pkg::gpa_osc_type osc_mode_reg;
	logic strap_taken_reg;
	logic [1:0] clk_div_reg;
	logic clk_out_reg;
	logic [WIDTH-1:0] port_mask;
	logic [WIDTH-1:0] analog_mask;
	logic [WIDTH-1:0] pin_read;
	logic [WIDTH-1:0] drv_val;
	logic [WIDTH-1:0] drv_en;
	logic [7:0] read_word;
	logic addr_hit;
	logic access;
	logic wr_done;

	gpa_pad_stage #(.WIDTH(WIDTH)) pads (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(pin_in),
		.pin_out(pin_out),
		.pin_oe(pin_oe),
		.padi(padi)
	);

	// pins carrying converter inputs for a given analog configuration
	function automatic logic [WIDTH-1:0] adc_pins(input logic [3:0] cfg);
		logic [WIDTH-1:0] m;
		m = '0;
		m[0] = (cfg != gpa_pkg::CFG_ALL_DIGITAL);
		m[1] = (cfg != gpa_pkg::CFG_ALL_DIGITAL);
		m[2] = (cfg < gpa_pkg::CFG_REF_LIMIT);
		m[3] = (cfg < gpa_pkg::CFG_REF_LIMIT);
		m[gpa_pkg::PIN_SLAVE_SEL] = !cfg[gpa_pkg::CFG_SS_BIT];
		return m;
	endfunction

	// oscillator mode strap, caught once after reset release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_mode_reg <= gpa_pkg::OSC_CRYSTAL;
			strap_taken_reg <= 1'b0;
		end
		else if (!strap_taken_reg)
		begin
			osc_mode_reg <= gpa_pkg::gpa_osc_type'(osc_mode_strap);
			strap_taken_reg <= 1'b1;
		end
	end

	always_comb
	begin
		port_mask = '1;
		case (osc_mode_reg)
			gpa_pkg::OSC_CRYSTAL:
			begin
				port_mask[gpa_pkg::PIN_OSC_OUT] = 1'b0;
				port_mask[gpa_pkg::PIN_OSC_IN] = 1'b0;
			end
			gpa_pkg::OSC_EXT_CLOCK:
				port_mask[gpa_pkg::PIN_OSC_IN] = 1'b0;
			gpa_pkg::OSC_RC_CLKOUT:
			begin
				port_mask[gpa_pkg::PIN_OSC_OUT] = 1'b0;
				port_mask[gpa_pkg::PIN_OSC_IN] = 1'b0;
			end
			gpa_pkg::OSC_INTERNAL:
				port_mask = '1;
			default:
				port_mask = '1;
		endcase
	end

	always_comb
	begin
		analog_mask = adc_pins(acfg_reg[gpa_pkg::CFG_LSB +: 4]);
		if (cmp_reg[gpa_pkg::CMP_MODE_LSB +: 3] != gpa_pkg::CMP_MODE_OFF)
			analog_mask[3:0] = 4'hf;
		if (cvr_reg[gpa_pkg::CVR_EN_BIT] && cvr_reg[gpa_pkg::CVR_OE_BIT])
			analog_mask[gpa_pkg::PIN_REF_OUT] = 1'b1;
	end

	assign pin_read = padi.level & ~analog_mask & port_mask;

	// driver control toward the pad stage
	always_comb
	begin
		drv_en = ~port_direction_reg & port_mask;
		drv_val = output_latch_bits_reg;
		if (cmp_reg[gpa_pkg::CMP_MODE_LSB +: 3] == gpa_pkg::CMP_MODE_OUT)
		begin
			drv_val[gpa_pkg::PIN_OPEN_DRAIN] = comparator_one_output;
			drv_val[gpa_pkg::PIN_SLAVE_SEL] = comparator_two_output;
		end
		if (timer_clock_enable)
			drv_en[gpa_pkg::PIN_OPEN_DRAIN] = 1'b0;
		if (slave_select_enable)
			drv_en[gpa_pkg::PIN_SLAVE_SEL] = 1'b0;
		drv_en[gpa_pkg::PIN_OPEN_DRAIN] = drv_en[gpa_pkg::PIN_OPEN_DRAIN]
			& !drv_val[gpa_pkg::PIN_OPEN_DRAIN];
		drv_val[gpa_pkg::PIN_OPEN_DRAIN] = 1'b0;
		if (osc_mode_reg == gpa_pkg::OSC_RC_CLKOUT)
		begin
			drv_en[gpa_pkg::PIN_OSC_OUT] = 1'b1;
			drv_val[gpa_pkg::PIN_OSC_OUT] = clk_out_reg;
		end
	end

	assign padi.drive_val = drv_val;
	assign padi.drive_en = drv_en;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_div_reg <= '0;
			clk_out_reg <= 1'b0;
		end
		else
		begin
			// wrap keeps the period at four clocks
			if (clk_div_reg == gpa_pkg::CLK_DIV_MAX)
				clk_div_reg <= '0;
			else
				clk_div_reg <= clk_div_reg + 2'h1;
			if (clk_div_reg[0])
				clk_out_reg <= !clk_out_reg;
		end
	end

	// apb slave: one wait state, answer on second access cycle
	assign access = psel && penable;
	assign wr_done = access && pready && pwrite;

	always_comb
	begin
		addr_hit = 1'b1;
		read_word = 8'h00;
		case (paddr)
			gpa_pkg::ADDR_PIN_DATA:
				read_word = pin_read;
			gpa_pkg::ADDR_DIRECTION:
				read_word = port_direction_reg & port_mask;
			gpa_pkg::ADDR_CMP_CTRL:
			begin
				read_word = cmp_reg;
				read_word[gpa_pkg::CMP_OUT_TWO_BIT] = comparator_two_output;
				read_word[gpa_pkg::CMP_OUT_ONE_BIT] = comparator_one_output;
			end
			gpa_pkg::ADDR_CMP_REF:
				read_word = cvr_reg;
			gpa_pkg::ADDR_ANALOG_CFG:
				read_word = acfg_reg;
			default:
				addr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= access && !pready;
			pslverr <= access && !pready && !addr_hit;
			if (access && !pready && !pwrite)
				prdata <= {24'h000000, read_word};
			else if (!access)
				prdata <= '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			output_latch_bits_reg <= gpa_pkg::RST_LATCH;
		else if (wr_done && paddr == gpa_pkg::ADDR_PIN_DATA)
			output_latch_bits_reg <= pwdata[7:0] & port_mask;
		else
			output_latch_bits_reg <= output_latch_bits_reg & port_mask;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port_direction_reg <= gpa_pkg::RST_DIRECTION;
		else if (wr_done && paddr == gpa_pkg::ADDR_DIRECTION)
			port_direction_reg <= pwdata[7:0] | ~port_mask;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmp_reg <= gpa_pkg::RST_CMP_CTRL;
			cvr_reg <= gpa_pkg::RST_CMP_REF;
			acfg_reg <= gpa_pkg::RST_ANALOG_CFG;
		end
		else if (wr_done)
		begin
			if (paddr == gpa_pkg::ADDR_CMP_CTRL)
				cmp_reg[gpa_pkg::CMP_RW_MSB:0] <= pwdata[gpa_pkg::CMP_RW_MSB:0];
			if (paddr == gpa_pkg::ADDR_CMP_REF)
				cvr_reg <= pwdata[7:0] & gpa_pkg::CVR_RW_MASK;
			if (paddr == gpa_pkg::ADDR_ANALOG_CFG)
				acfg_reg <= pwdata[7:0];
		end
	end

	// peripheral-facing outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_clock_input <= 1'b0;
			slave_select_n <= 1'b1;
			analog_select <= '0;
			comparator_control <= gpa_pkg::RST_CMP_CTRL;
			comparator_reference_control <= gpa_pkg::RST_CMP_REF;
			analog_pin_config <= gpa_pkg::RST_ANALOG_CFG;
		end
		else
		begin
			timer_clock_input <= padi.level[gpa_pkg::PIN_OPEN_DRAIN];
			slave_select_n <= padi.level[gpa_pkg::PIN_SLAVE_SEL]
				| analog_mask[gpa_pkg::PIN_SLAVE_SEL] | !slave_select_enable;
			analog_select <= analog_mask;
			comparator_control <= cmp_reg;
			comparator_reference_control <= cvr_reg;
			analog_pin_config <= acfg_reg;
		end
	end
endmodule // gpa_port
`default_nettype wire

// ==== testbench/gpa_port_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpa_port_assertions #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic [WIDTH-1:0] pin_out,
	input wire logic [WIDTH-1:0] pin_oe,
	input wire logic [1:0] osc_mode_strap,
	input wire logic timer_clock_enable,
	input wire logic slave_select_enable,
	input wire logic slave_select_n
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_od;
		!pin_out[4];
	endproperty
	a_od: assert property (p_od)
		else $error("open-drain pin driven high");
	property p_tmr;
		timer_clock_enable |=> !pin_oe[4];
	endproperty
	a_tmr: assert property (p_tmr)
		else $error("timer pin still driven");
	property p_ss_drv;
		slave_select_enable |=> !pin_oe[5];
	endproperty
	a_ss_drv: assert property (p_ss_drv)
		else $error("slave select pin still driven");
	property p_ss_idle;
		!slave_select_enable |=> slave_select_n;
	endproperty
	a_ss_idle: assert property (p_ss_idle)
		else $error("slave select active while disabled");
	property p_wait;
		$rose(penable) && psel |-> !pready ##1 pready;
	endproperty
	a_wait: assert property (p_wait)
		else $error("answer not after one wait state");
	property p_err;
		pslverr |-> pready && psel && penable;
	endproperty
	a_err: assert property (p_err)
		else $error("error outside a transfer end");
	property p_upper;
		pready |-> prdata[31:8] == 24'h000000;
	endproperty
	a_upper: assert property (p_upper)
		else $error("upper read data not zero");
	property p_osc;
		osc_mode_strap == 2'b00 |-> pin_oe[7:6] == 2'b00;
	endproperty
	a_osc: assert property (p_osc)
		else $error("oscillator pins driven as port");
	property p_clkout;
		osc_mode_strap == 2'b10 [*8] |-> pin_out[6] != $past(pin_out[6], 2);
	endproperty
	a_clkout: assert property (p_clkout)
		else $error("clock out not a quarter of clock");
endmodule // gpa_port_assertions
bind gpa_port gpa_port_assertions #(.WIDTH(WIDTH)) i_chk (.pclk, .presetn, .psel, .penable,
	.pready, .pslverr, .prdata, .pin_out, .pin_oe, .osc_mode_strap, .timer_clock_enable,
	.slave_select_enable, .slave_select_n);
`default_nettype wire

// ==== testbench/gpa_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpa_pin_model (
	input wire logic pclk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	output logic [7:0] pin_in
);
	logic [7:0] last_reg;
	// port drive wins, open drain pulled up, floating pins wander
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (i == 4)
				pin_in[i] = 1'b1;
			else
				pin_in[i] = ~last_reg[i];
		end
	end
	always_ff @(posedge pclk)
		last_reg <= pin_in;
endmodule // gpa_pin_model
`default_nettype wire

// ==== testbench/eight_bit_gpio_port_with_analog_mux_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module eight_bit_gpio_port_with_analog_mux_tb;
	localparam logic [11:0] A_DAT = gpa_pkg::ADDR_PIN_DATA;
	localparam logic [11:0] A_DIR = gpa_pkg::ADDR_DIRECTION;
	localparam logic [11:0] A_CMP = gpa_pkg::ADDR_CMP_CTRL;
	localparam logic [11:0] A_CVR = gpa_pkg::ADDR_CMP_REF;
	localparam logic [11:0] A_CFG = gpa_pkg::ADDR_ANALOG_CFG;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic tce = 1'b0;
	logic sse = 1'b0;
	logic c1 = 1'b0;
	logic c2 = 1'b0;
	logic ck;
	logic [7:0] cc, crc, apc;
	logic [1:0] strap = 2'b00;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [7:0] ev = 8'hff;
	logic [7:0] ee = 8'hff;
	logic [31:0] prdata;
	logic pready, pslverr, ss_n, tci, err;
	logic [7:0] pin_in, pin_out, pin_oe, asel, rd;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	gpa_port i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .pin_in, .pin_out, .pin_oe, .osc_mode_strap(strap),
		.timer_clock_enable(tce), .slave_select_enable(sse), .comparator_one_output(c1),
		.comparator_two_output(c2), .timer_clock_input(tci), .slave_select_n(ss_n),
		.analog_select(asel), .comparator_control(cc), .comparator_reference_control(crc),
		.analog_pin_config(apc));
	gpa_pin_model i_pins (.pclk, .pin_out, .pin_oe, .ext_val(ev), .ext_en(ee), .pin_in);
	initial
	begin
		forever #12.5 pclk = ~pclk;
	end
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			fails++;
			end_sim();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// pins need a few cycles through the synchronisers before a read
	task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
		repeat (4) @(posedge pclk);
		apb(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask
	task automatic rst(input logic [1:0] s);
		presetn <= 1'b0;
		strap <= s;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	initial
	begin
		rst(2'b00);
		rdchk(A_DIR, 8'h3f);
		rdchk(A_CMP, 8'h07);
		rdchk(A_CFG, 8'h00);
		rdchk(A_CVR, 8'h00);
		rdchk(A_DAT, 8'h10);
		chk(asel, 8'h2f);
		chk(cc, 8'h07);
		chk(crc, 8'h00);
		chk(apc, 8'h00);
		$display("reset test done");
		apb(1'b1, A_CFG, 8'h0f);
		rdchk(A_DAT, 8'h3f);
		apb(1'b1, A_DAT, 8'h35);
		apb(1'b1, A_DIR, 8'h00);
		ee <= 8'hef;
		rdchk(A_DAT, 8'h35);
		chk(pin_oe, 8'h2f);
		chk(pin_out, 8'h25);
		apb(1'b1, A_DIR, 8'hff);
		rdchk(A_DIR, 8'h3f);
		chk(pin_oe, 8'h00);
		$display("direction test done");
		apb(1'b1, A_DAT, 8'h20);
		apb(1'b1, A_DIR, 8'h00);
		apb(1'b1, A_CFG, 8'h04);
		rdchk(A_DAT, 8'h20);
		chk(asel, 8'h0f);
		chk(apc, 8'h04);
		chk(pin_oe, 8'h3f);
		tce <= 1'b1;
		sse <= 1'b1;
		ev <= 8'hdf;
		rdchk(A_DIR, 8'h00);
		chk(pin_oe, 8'h0f);
		chk({7'h00, tci}, 8'h01);
		chk({7'h00, ss_n}, 8'h00);
		tce <= 1'b0;
		sse <= 1'b0;
		$display("sharing test done");
		c1 <= 1'b1;
		c2 <= 1'b1;
		apb(1'b1, A_CMP, 8'h06);
		apb(1'b1, A_CFG, 8'h0f);
		rdchk(A_CMP, 8'hc6);
		chk(asel, 8'h0f);
		chk(cc, 8'h06);
		chk(pin_oe, 8'h2f);
		apb(1'b1, A_CVR, 8'hff);
		rdchk(A_CVR, 8'hef);
		chk(crc, 8'hef);
		apb(1'b1, 12'h000, 8'h55);
		chk({7'h00, err}, 8'h01);
		rdchk(12'h000, 8'h00);
		$display("comparator test done");
		rst(2'b11);
		apb(1'b1, A_DAT, 8'h80);
		apb(1'b1, A_DIR, 8'h7f);
		rdchk(A_DIR, 8'h7f);
		rdchk(A_DAT, 8'hd0);
		rst(2'b10);
		repeat (30) @(posedge pclk);
		rdchk(A_DIR, 8'h3f);
		chk(pin_oe, 8'h40);
		ck = pin_out[6];
		repeat (2) @(posedge pclk);
		chk({7'h00, pin_out[6]}, {7'h00, ~ck});
		repeat (2) @(posedge pclk);
		chk({7'h00, pin_out[6]}, {7'h00, ck});
		rst(2'b01);
		apb(1'b1, A_DIR, 8'hbf);
		rdchk(A_DIR, 8'h3f);
		chk(pin_oe, 8'h40);
		$display("oscillator test done");
		end_sim();
	end
endmodule // eight_bit_gpio_port_with_analog_mux_tb
`default_nettype wire
